/* File: core/rdio_pkg.sv */
// Package for the dedicated remote input/output handler.
// Assumes one 40 MHz clock and a synchronous active-low reset in every user.
package rdio_pkg;

  // ----------------------------------------------------------------
  // Sizes and fixed assignments
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 32;
  localparam int NUM_INPUTS = 32;
  localparam int HALT_INPUT_INDEX = 0;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 25;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic RST_FAULT = 1'b0;
  localparam logic RST_EMERGENCY = 1'b0;
  localparam logic RST_DRIVE_ON = 1'b0;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_CYCLE_STOP = 1'b0;
  localparam logic RST_EVASION = 1'b0;

  // ----------------------------------------------------------------
  // Dedicated request pins, one bit each
  // ----------------------------------------------------------------
  typedef struct packed {
    logic startAll;
    logic programWaitClear;
    logic faultClearRequest;
    logic cycleStop;
    logic drivePowerOff;
    logic drivePowerOn;
    logic operationRightsRequest;
    logic mechanismLock;
    logic evasionReturnRequest;
    logic generalOutputClear;
  } rdio_req_t;

  // ----------------------------------------------------------------
  // Dedicated status outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic waitStatus;
    logic selectEnabled;
    logic faultActive;
    logic cycleStopping;
    logic drivePowerOffEcho;
    logic drivePowerIsOn;
    logic rightsValid;
    logic lockActive;
    logic evasionActive;
    logic emergencyIndication;
    logic anyOperating;
  } rdio_stat_t;

  typedef enum logic [1:0] {
    SLOT_IDLE,
    SLOT_RUN,
    SLOT_WAIT
  } rdio_slot_t;

endpackage : rdio_pkg

/* File: core/rdio_remote_io.sv */
// Dedicated remote-control input/output handler of a robot controller.
// Assumes request pins and general inputs come from an outside controller
// (synchronised here); fault, emergency and motion-done events come from
// device logic on clk.
// Status outputs follow a request pin after three to four clock edges; the
// general outputs themselves live elsewhere, only their clear pulse leaves.
//
// Notes on behaviour
// - Halt held: all running slots wait
// - Fixed halt sits on input number zero
// - Second halt on configurable input number
// - Program reset clears wait, enables selection
// - Fault clear request leaves error state
// - Fault output held until cleared
// - Cycle stop shown while in progress
// - Power-off held forces drives off, echoed
// - Power-on request turns drives on
// - Operation rights validity reported on output
// - Lock request sets or clears lock
// - Evasion return shown while in progress
// - Output clear resets general outputs
// - Emergency indication when emergency occurred
// - Thirty-two slot starts, per-slot operating outputs
// - Start-all starts every slot, operating shown
`timescale 1ns/1ps

module rdio_remote_io #(
  parameter int NUM_SLOTS = rdio_pkg::NUM_SLOTS,
  parameter int NUM_INPUTS = rdio_pkg::NUM_INPUTS,
  parameter int IDX_W = $clog2(rdio_pkg::NUM_INPUTS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_INPUTS-1:0] generalInputs,
  input wire logic [IDX_W-1:0] assignableHaltIndex,
  input wire rdio_pkg::rdio_req_t dedicatedReq,
  input wire logic [NUM_SLOTS-1:0] slotStart,
  input wire logic remoteModeActive,
  input wire logic [NUM_SLOTS-1:0] slotCycleDone,
  input wire logic errorEvent,
  input wire logic emergencyEvent,
  input wire logic evasionDone,
  output rdio_pkg::rdio_stat_t status,
  output logic [NUM_SLOTS-1:0] slotOperating,
  output logic [NUM_SLOTS-1:0] slotWait,
  output logic generalOutputClearPulse
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int REQ_W = $bits(rdio_pkg::rdio_req_t);
  localparam int PIN_W = NUM_INPUTS + REQ_W + NUM_SLOTS;

  logic [PIN_W-1:0] pinMeta_q;
  logic [PIN_W-1:0] pinSync_q;
  logic [PIN_W-1:0] pinPrev_q;
  logic [PIN_W-1:0] pinRise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
    end else begin
      pinMeta_q <= {generalInputs, dedicatedReq, slotStart};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  // Prev resets low, so a pin already high at release counts as one edge
  // Edge inputs act on rise only
  assign pinRise = pinSync_q & ~pinPrev_q;

  wire logic [NUM_INPUTS-1:0] inLevel = pinSync_q[PIN_W-1 -: NUM_INPUTS];
  wire rdio_pkg::rdio_req_t reqLevel = pinSync_q[NUM_SLOTS +: REQ_W];
  wire rdio_pkg::rdio_req_t reqRise = pinRise[NUM_SLOTS +: REQ_W];
  wire logic [NUM_SLOTS-1:0] slotStartRise = pinRise[NUM_SLOTS-1:0];

  // ----------------------------------------------------------------
  // Halt sources
  // ----------------------------------------------------------------
  // Fixed halt input number
  wire logic fixedHalt = inLevel[rdio_pkg::HALT_INPUT_INDEX];
  wire logic assignableHalt = inLevel[assignableHaltIndex];
  wire logic haltActive = fixedHalt | assignableHalt;

  // ----------------------------------------------------------------
  // Device state registers
  // ----------------------------------------------------------------
  logic fault_q;
  logic fault_d;
  logic emergency_q;
  logic emergency_d;
  logic driveOn_q;
  logic driveOn_d;
  logic lock_q;
  logic lock_d;
  logic cycleStop_q;
  logic cycleStop_d;
  logic evasion_q;
  logic evasion_d;
  logic outClear_q;
  rdio_pkg::rdio_slot_t slot_q [NUM_SLOTS];
  rdio_pkg::rdio_slot_t slot_d [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] running;
  logic [NUM_SLOTS-1:0] idle;
  logic [NUM_SLOTS-1:0] waiting;

  // Emergency is a stop that needs no request from the controller
  wire logic stopAll = haltActive | emergency_q | emergencyEvent;

  // ----------------------------------------------------------------
  // Fault and emergency flags
  // ----------------------------------------------------------------
  // Set wins over clear so a fault at the clearing edge survives
  // Clear on request edge
  assign fault_d = errorEvent | (fault_q & ~reqRise.faultClearRequest);

  // One clear edge drops emergency too; a live event sets it again
  // Emergency sticky, held while present
  assign emergency_d = emergencyEvent | (emergency_q & ~reqRise.faultClearRequest);

  // ----------------------------------------------------------------
  // Drive power and lock
  // ----------------------------------------------------------------
  // Power-off level dominates any power-on edge in the same cycle
  // Held off while input active
  assign driveOn_d = (reqLevel.drivePowerOff | emergency_d) ? 1'b0 :
                     (reqRise.drivePowerOn | driveOn_q);

  // Toggling: the controller reads the lock output to know the state
  // Each request edge flips lock
  assign lock_d = lock_q ^ reqRise.mechanismLock;

  // ----------------------------------------------------------------
  // Cycle stop and evasion return
  // ----------------------------------------------------------------
  // Ignored with no slot running, so nothing is left latched
  // Active until no slot runs
  assign cycleStop_d = (reqRise.cycleStop & (|running)) |
                       (cycleStop_q & (|running));

  // Halt or emergency aborts the return at once
  // Active until motion reports done
  assign evasion_d = (reqRise.evasionReturnRequest & driveOn_q & ~stopAll) |
                     (evasion_q & ~evasionDone & ~stopAll);

  // ----------------------------------------------------------------
  // Start requests
  // ----------------------------------------------------------------
  // Starting needs drives on and no fault; a cycle stop in progress
  // blocks new starts so the stop can complete
  wire logic startAllowed = driveOn_q & ~fault_q & ~cycleStop_q & ~evasion_q & ~stopAll;
  // Own start reaches its own slot only
  wire logic [NUM_SLOTS-1:0] startReq =
      {NUM_SLOTS{startAllowed}} & ({NUM_SLOTS{reqRise.startAll}} | slotStartRise);

  // ----------------------------------------------------------------
  // Per-slot sequencing
  // ----------------------------------------------------------------

  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_d[i] = slot_q[i];
      unique case (slot_q[i])
        rdio_pkg::SLOT_RUN: begin
          // Halt puts running slot in wait
          if (stopAll | ~driveOn_q) begin
            slot_d[i] = rdio_pkg::SLOT_WAIT;
          end else if (slotCycleDone[i]) begin
            slot_d[i] = rdio_pkg::SLOT_IDLE;
          end
        end
        rdio_pkg::SLOT_WAIT: begin
          if (reqRise.programWaitClear) begin
            slot_d[i] = rdio_pkg::SLOT_IDLE;
          end else if (startReq[i]) begin
            slot_d[i] = rdio_pkg::SLOT_RUN;
          end
        end
        rdio_pkg::SLOT_IDLE: begin
          if (startReq[i]) begin
            slot_d[i] = rdio_pkg::SLOT_RUN;
          end
        end
        default: begin
          // Unused state code falls back to idle
          slot_d[i] = rdio_pkg::SLOT_IDLE;
        end
      endcase
    end
  end

  // Summary vectors share one state compare
  function automatic logic slotIn(
    input rdio_pkg::rdio_slot_t s,
    input rdio_pkg::rdio_slot_t v
  );
    return s == v;
  endfunction : slotIn

  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      running[i] = slotIn(slot_q[i], rdio_pkg::SLOT_RUN);
      idle[i] = slotIn(slot_q[i], rdio_pkg::SLOT_IDLE);
      waiting[i] = slotIn(slot_q[i], rdio_pkg::SLOT_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // State flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_q <= rdio_pkg::RST_FAULT;
      emergency_q <= rdio_pkg::RST_EMERGENCY;
      driveOn_q <= rdio_pkg::RST_DRIVE_ON;
      lock_q <= rdio_pkg::RST_LOCK;
      cycleStop_q <= rdio_pkg::RST_CYCLE_STOP;
      evasion_q <= rdio_pkg::RST_EVASION;
      outClear_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      emergency_q <= emergency_d;
      driveOn_q <= driveOn_d;
      lock_q <= lock_d;
      cycleStop_q <= cycleStop_d;
      evasion_q <= evasion_d;
      outClear_q <= reqRise.generalOutputClear;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (!rst_n) begin
        slot_q[i] <= rdio_pkg::SLOT_IDLE;
      end else begin
        slot_q[i] <= slot_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Registered so every output comes straight from a flip-flop;
  // status lags internal state by one clock
  rdio_pkg::rdio_stat_t stat_q;
  logic [NUM_SLOTS-1:0] slotOp_q;
  logic [NUM_SLOTS-1:0] slotWait_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= '0;
      slotOp_q <= '0;
      slotWait_q <= '0;
    end else begin
      // Wait output while any slot waits
      stat_q.waitStatus <= |waiting;
      // Selection enabled when all slots idle
      stat_q.selectEnabled <= &idle;
      stat_q.faultActive <= fault_q;
      stat_q.cycleStopping <= cycleStop_q;
      stat_q.drivePowerOffEcho <= reqLevel.drivePowerOff;
      stat_q.drivePowerIsOn <= driveOn_q;
      // No other request is gated by rights; interlocking is outside
      // Rights valid only in remote mode
      stat_q.rightsValid <= reqLevel.operationRightsRequest & remoteModeActive;
      stat_q.lockActive <= lock_q;
      stat_q.evasionActive <= evasion_q;
      stat_q.emergencyIndication <= emergency_q;
      stat_q.anyOperating <= |running;
      slotOp_q <= running;
      slotWait_q <= waiting;
    end
  end

  assign status = stat_q;
  assign slotOperating = slotOp_q;
  assign slotWait = slotWait_q;
  assign generalOutputClearPulse = outClear_q;

endmodule : rdio_remote_io

/* File: verif/rdio_remote_io_props.sv */
// Checker for the remote input/output handler, bound to its top module.
// Assumes pins stay steady for several edges per request.
`timescale 1ns/1ps
module rdio_remote_io_props #(
  parameter int NUM_SLOTS = 32,
  parameter int NUM_INPUTS = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_INPUTS-1:0] generalInputs,
  input wire rdio_pkg::rdio_req_t dedicatedReq,
  input wire logic remoteModeActive,
  input wire logic errorEvent,
  input wire logic emergencyEvent,
  input wire rdio_pkg::rdio_stat_t status,
  input wire logic [NUM_SLOTS-1:0] slotOperating,
  input wire logic [NUM_SLOTS-1:0] slotWait,
  input wire logic generalOutputClearPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Held long enough to cross the synchroniser
  sequence sHalt; generalInputs[0] [*7]; endsequence
  sequence sOff; dedicatedReq.drivePowerOff [*7]; endsequence
  sequence sNoClear; (status.faultActive && !dedicatedReq.faultClearRequest) [*6]; endsequence
  AST_HALT: assert property (sHalt |-> slotOperating == '0)
    else $error("slot runs during halt");
  AST_OFF: assert property (sOff |-> status.drivePowerOffEcho && !status.drivePowerIsOn)
    else $error("power-off not obeyed");
  AST_FAULT_HOLD: assert property (sNoClear |=> status.faultActive)
    else $error("fault dropped without clear");
  AST_FAULT_SET: assert property (errorEvent |-> ##[2:3] status.faultActive)
    else $error("fault not raised");
  AST_EMG_SET: assert property (emergencyEvent |-> ##[2:3] status.emergencyIndication)
    else $error("emergency not shown");
  AST_RIGHTS: assert property (status.rightsValid |-> $past(remoteModeActive))
    else $error("rights valid outside remote mode");
  AST_WAIT_ANY: assert property (status.waitStatus == (slotWait != '0))
    else $error("wait status disagrees with slots");
  AST_OPER_ANY: assert property (status.anyOperating == (slotOperating != '0))
    else $error("operating status disagrees with slots");
  AST_SELECT: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3)
    |-> status.selectEnabled == ((slotOperating | slotWait) == '0))
    else $error("selection enable wrong");
  AST_EXCL: assert property ((slotOperating & slotWait) == '0)
    else $error("slot both running and waiting");
  AST_GOC: assert property (generalOutputClearPulse |=> !generalOutputClearPulse)
    else $error("output clear pulse too long");
endmodule : rdio_remote_io_props
bind rdio_remote_io rdio_remote_io_props #(.NUM_SLOTS(NUM_SLOTS), .NUM_INPUTS(NUM_INPUTS)) chk (
  .clk(clk), .rst_n(rst_n), .generalInputs(generalInputs), .dedicatedReq(dedicatedReq),
  .remoteModeActive(remoteModeActive), .errorEvent(errorEvent), .emergencyEvent(emergencyEvent),
  .status(status), .slotOperating(slotOperating), .slotWait(slotWait),
  .generalOutputClearPulse(generalOutputClearPulse));

/* File: verif/rdio_ctrl_model.sv */
// Outside controller model driving the dedicated request pins.
// Assumes callers run from the bench's main process on clk.
`timescale 1ns/1ps
module rdio_ctrl_model (
  input wire logic clk,
  output rdio_pkg::rdio_req_t dedicatedReq,
  output logic [31:0] slotStart,
  output logic [31:0] generalInputs
);
  rdio_pkg::rdio_req_t edgeReq = '0;
  rdio_pkg::rdio_req_t lvlReq = '0;
  assign dedicatedReq = rdio_pkg::rdio_req_t'(edgeReq | lvlReq);
  initial begin
    slotStart = '0;
    generalInputs = '0;
  end
  task automatic pulse(input rdio_pkg::rdio_req_t m, input logic [31:0] s);
    @(posedge clk);
    #2;
    edgeReq = m;
    slotStart = s;
    repeat (3) @(posedge clk);
    #2;
    edgeReq = '0;
    slotStart = '0;
    repeat (5) @(posedge clk);
    #2;
  endtask : pulse
  // Ordinary halts only, never safety stops
  task automatic setGi(input logic [31:0] g);
    @(posedge clk);
    #2;
    generalInputs = g;
  endtask : setGi
  task automatic setLvl(input rdio_pkg::rdio_req_t m);
    @(posedge clk);
    #2;
    lvlReq = m;
  endtask : setLvl
endmodule : rdio_ctrl_model

/* File: verif/testbench.sv */
// Self-checking bench for the remote input/output handler.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin numErrors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic clk;
  logic rst_n;
  logic [4:0] haltIdx;
  logic remoteMode;
  logic [31:0] cycleDone;
  logic errEv;
  logic emgEv;
  logic evDone;
  logic gocPulse;
  logic [3:0] cnt;
  logic [31:0] slotOp;
  logic [31:0] slotWt;
  logic [31:0] starts;
  logic [31:0] gi;
  rdio_pkg::rdio_req_t req;
  rdio_pkg::rdio_stat_t status;
  int numErrors = 0;
  int nTests = 0;
  int i;
  rdio_ctrl_model ctrl (.clk(clk), .dedicatedReq(req), .slotStart(starts), .generalInputs(gi));
  rdio_remote_io uut (.clk(clk), .rst_n(rst_n), .generalInputs(gi), .assignableHaltIndex(haltIdx),
    .dedicatedReq(req), .slotStart(starts), .remoteModeActive(remoteMode),
    .slotCycleDone(cycleDone), .errorEvent(errEv), .emergencyEvent(emgEv),
    .evasionDone(evDone), .status(status), .slotOperating(slotOp), .slotWait(slotWt),
    .generalOutputClearPulse(gocPulse));
  function automatic logic [31:0] oneHot(input int k);
    return 32'h0000_0001 << k;
  endfunction : oneHot
  function automatic rdio_pkg::rdio_stat_t idleStat();
    idleStat = '0;
    idleStat.selectEnabled = 1'b1;
    idleStat.faultActive = rdio_pkg::RST_FAULT;
    idleStat.drivePowerIsOn = rdio_pkg::RST_DRIVE_ON;
    idleStat.lockActive = rdio_pkg::RST_LOCK;
  endfunction : idleStat
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic ed(input int b);
    ctrl.pulse(rdio_pkg::rdio_req_t'(10'h001 << b), 32'h0000_0000);
  endtask : ed
  task automatic printVerdict();
    $display("errors=%0d tests=%0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : printVerdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #100_000;
    numErrors++;
    printVerdict();
  end
  initial begin
    rst_n = 1'b0;
    haltIdx = 5'h00;
    remoteMode = 1'b0;
    cycleDone = '0;
    errEv = 1'b0;
    emgEv = 1'b0;
    evDone = 1'b0;
    void'($urandom(32'hd8bb));
    repeat (10) @(posedge clk);
    #2;
    rst_n = 1'b1;
    step(3);
    `CHK(status, idleStat())
    ed(4);
    `CHK(status.drivePowerIsOn, 1'b1)
    i = $urandom_range(31, 0);
    ctrl.pulse('0, oneHot(i));
    `CHK(slotOp, oneHot(i))
    `CHK({status.anyOperating, status.selectEnabled}, 2'b10)
    // Noise on other lines must not matter
    ctrl.setGi($urandom() | 32'h0000_0001);
    step(7);
    `CHK({status.waitStatus, slotOp, slotWt}, {1'b1, 32'h0, oneHot(i)})
    ctrl.setGi('0);
    ed(8);
    `CHK({status.selectEnabled, status.waitStatus, slotWt}, {2'b10, 32'h0})
    haltIdx = 5'($urandom_range(31, 1));
    ed(9);
    `CHK(slotOp, 32'hFFFF_FFFF)
    ctrl.setGi(oneHot(haltIdx));
    step(7);
    `CHK(slotWt, 32'hFFFF_FFFF)
    ctrl.setGi('0);
    ed(8);
    `CHK(slotWt | slotOp, 32'h0)
    i = $urandom_range(31, 0);
    ctrl.pulse('0, oneHot(i));
    ed(6);
    `CHK(status.cycleStopping, 1'b1)
    cycleDone = oneHot(i);
    step(1);
    cycleDone = '0;
    step(4);
    `CHK({status.cycleStopping, slotOp}, 33'h0)
    for (i = 0; i < 2; i++) begin
      ed(2);
      `CHK(status.lockActive, i == 0)
    end
    ed(1);
    `CHK(status.evasionActive, 1'b1)
    evDone = 1'b1;
    step(1);
    evDone = 1'b0;
    step(2);
    `CHK(status.evasionActive, 1'b0)
    ctrl.setLvl(rdio_pkg::rdio_req_t'(10'h008));
    for (i = 0; i < 2; i++) begin
      remoteMode = (i == 1);
      step(7);
      `CHK(status.rightsValid, i == 1)
    end
    ctrl.setLvl('0);
    cnt = '0;
    fork
      ed(0);
      repeat (12) begin
        @(posedge clk);
        #2;
        cnt += {3'h0, gocPulse};
      end
    join
    `CHK(cnt, 4'h1)
    errEv = 1'b1;
    step(1);
    errEv = 1'b0;
    step(6);
    `CHK(status.faultActive, 1'b1)
    ed(7);
    `CHK(status.faultActive, 1'b0)
    emgEv = 1'b1;
    step(1);
    emgEv = 1'b0;
    step(3);
    `CHK({status.emergencyIndication, status.drivePowerIsOn}, 2'b10)
    ed(7);
    ed(4);
    `CHK({status.emergencyIndication, status.drivePowerIsOn}, 2'b01)
    ctrl.setLvl(rdio_pkg::rdio_req_t'(10'h020));
    step(7);
    `CHK({status.drivePowerOffEcho, status.drivePowerIsOn}, 2'b10)
    ctrl.setLvl('0);
    step(7);
    `CHK(status.drivePowerOffEcho, 1'b0)
    printVerdict();
  end
endmodule : testbench
